// ==== shared/sr_cfg.svh ====
`ifndef SR_CFG_SVH
`define SR_CFG_SVH
// ======================================================
// sizes of the burst store
`define SR_DATA_W 18
`define SR_LANE_W 9
`define SR_LANES 2
`define SR_ADDR_W 8
`define SR_BEAT_W 2
`define SR_FIFO_DEPTH 16
// free fifo slots needed before a write is taken (two bursts)
`define SR_WR_ROOM 8
// ======================================================
// reset values
`define SR_DATA_RST 18'h00000
`define SR_MASK_RST 2'h3
`endif

// ==== shared/sr_pkg.sv ====
`include "sr_cfg.svh"
package sr_pkg;
  // ======================================================
  // bus-cycle states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, // no burst running
    ST_LEAD = 3'h2, // request taken, data one period away
    ST_BEAT = 3'h4  // four beats moving
  } cycle_st_t;

  // ======================================================
  // one write beat on its way to the array
  typedef struct packed {
    logic [`SR_ADDR_W+`SR_BEAT_W-1:0] addr; // burst address
    logic [`SR_LANES-1:0] lane_write_en_n;  // per-lane strobes
    logic [`SR_DATA_W-1:0] data;            // beat data
  } wbeat_t;
endpackage : sr_pkg

// ==== rtl/burst_sram_bus.sv ====
`timescale 1ns/1ps
`include "sr_cfg.svh"
// ======================================================
// write beat buffer
module beat_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,           // core clock
  input wire logic rst_n_in,         // async reset, low
  input wire logic in_valid_in,      // push request
  output logic in_ready_out,         // room for one word
  input wire logic [W-1:0] in_data_in, // pushed word
  output logic out_valid_out,        // word available
  input wire logic out_ready_in,     // drain accepts
  output logic [W-1:0] out_data_out, // head word
  output logic [AW:0] level_out      // words held
);
  logic [W-1:0] store [DEPTH]; // word storage
  logic [AW:0] wp, rp;         // pointers with wrap bit
  logic [AW:0] next_wp, next_rp;
  logic push, pop;

  // ======================================================
  // pointer update
  always_comb begin
    // level first: ready is derived from it in this same pass
    level_out = wp - rp;
    in_ready_out = (level_out != DEPTH[AW:0]);
    out_valid_out = (wp != rp);
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    out_data_out = store[rp[AW-1:0]];
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  // storage carries no reset; pointers guard it
  always_ff @(posedge clk_in) begin
    if (push) begin
      store[wp[AW-1:0]] <= in_data_in;
    end
  end
endmodule : beat_fifo

// Notes on behaviour
// R01: lane low writes its nine bits
// R02: strobes count only inside started write bursts
// R03: strobes taken fresh with every beat
// R04: burst address is base plus 0..3
// R05: burst stops after exactly four beats
// R06: read and write machines run independently
// R07: simultaneous requests start only the read
// R08: state changes only on true edges
// R09: write beats on periods t+1, t+2
// R10: read beats on periods t+2, t+3
// R11: repeat request on next edge is ignored
// R12: requests sampled on true edges; idle is quiet
// R13: disabled lane keeps stored contents
// R14: each machine owns its address counter
module burst_sram_bus import sr_pkg::*; #(
  parameter int ADDR_W = `SR_ADDR_W,
  parameter int FIFO_DEPTH = `SR_FIFO_DEPTH
) (
  input wire logic CORE_CLK_IN,          // core clock, 2x link
  input wire logic RESET_N_IN,           // async reset, low
  input wire logic RD_REQ_N_IN,          // read request, low
  input wire logic WR_REQ_N_IN,          // write request, low
  input wire logic [ADDR_W-1:0] ADDR_IN, // burst base address
  input wire logic [`SR_DATA_W-1:0] WR_DATA_IN, // write beat
  input wire logic [`SR_LANES-1:0] LANE_WRITE_EN_N_IN, // lanes
  input wire logic DRAIN_HOLD_IN,        // stall array writes
  output logic K_PHASE_OUT,              // high: true-edge cycle
  output logic WR_READY_OUT,             // room for a write
  output logic [`SR_DATA_W-1:0] RD_DATA_OUT, // read beat
  output logic RD_OE_OUT                 // read beat driven
);
  localparam int MW = ADDR_W + `SR_BEAT_W;
  localparam int FAW = $clog2(FIFO_DEPTH);

  // ======================================================
  // link clock divider
  logic k_phase;      // toggles each core cycle
  logic next_k_phase;
  logic k_rise;       // one-cycle enable: true clock edge

  always_comb begin
    next_k_phase = ~k_phase;
    k_rise = ~k_phase;
    K_PHASE_OUT = k_rise;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      k_phase <= 1'b0;
    end else begin
      k_phase <= next_k_phase;
    end
  end

  // ======================================================
  // request decode, port 0 read and port 1 write
  logic [1:0] acc;       // request taken this edge
  logic [1:0] last_acc;  // taken on the previous true edge
  logic [1:0] cons;      // beat consumed this cycle
  logic wr_room;         // fifo has room for two bursts
  logic [FAW:0] fifo_level;

  always_comb begin
    wr_room = (FIFO_DEPTH[FAW:0] - fifo_level) >= `SR_WR_ROOM;
    WR_READY_OUT = wr_room;
    // strobes only looked at on true edges [R12]
    acc[0] = k_rise && !RD_REQ_N_IN && !last_acc[0]; // [R11]
    // read wins a tie [R07]
    acc[1] = k_rise && !WR_REQ_N_IN && RD_REQ_N_IN &&
             !last_acc[1] && wr_room; // [R11]
  end

  // ======================================================
  // two independent burst machines [R06]
  cycle_st_t st [2];                  // machine state
  logic [`SR_BEAT_W-1:0] beat [2];    // burst offset [R14]
  logic [ADDR_W-1:0] base [2];        // burst base [R14]
  logic [1:0] pend_v;                 // next burst queued
  logic [ADDR_W-1:0] pend_a [2];      // queued base
  logic [MW-1:0] burst_addr [2];      // base plus offset

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_mach
      cycle_st_t next_st;
      logic [`SR_BEAT_W-1:0] next_beat;
      logic [ADDR_W-1:0] next_base, next_pend_a;
      logic next_pend_v, next_last;

      // next state, changed only on true edges [R08]
      always_comb begin
        next_st = st[p];
        next_beat = beat[p];
        next_base = base[p];
        next_pend_v = pend_v[p];
        next_pend_a = pend_a[p];
        next_last = last_acc[p];
        cons[p] = (st[p] == ST_BEAT);
        burst_addr[p] = {base[p], beat[p]}; // [R04]
        if (cons[p]) begin
          next_beat = beat[p] + 1'b1; // +0,+1,+2,+3 [R04]
        end
        if (k_rise) begin
          next_last = acc[p];
          case (st[p])
            ST_IDLE: begin
              if (acc[p]) begin
                next_st = ST_LEAD;
                next_base = ADDR_IN;
              end
            end
            ST_LEAD: begin // beats start one period on [R09]
              next_st = ST_BEAT;
              next_beat = '0;
            end
            ST_BEAT: begin
              if (beat[p] == 2'h3) begin // fourth beat [R05]
                if (pend_v[p]) begin
                  // chained burst keeps the beat stream full
                  next_base = pend_a[p];
                  next_pend_v = 1'b0;
                end else if (acc[p]) begin
                  next_st = ST_LEAD;
                  next_base = ADDR_IN;
                end else begin
                  next_st = ST_IDLE; // counter parks [R05]
                end
              end else if (acc[p]) begin
                next_pend_v = 1'b1;
                next_pend_a = ADDR_IN;
              end
            end
            default: begin
              next_st = ST_IDLE;
            end
          endcase
        end
      end

      always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          st[p] <= ST_IDLE;
          beat[p] <= '0;
          base[p] <= '0;
          pend_v[p] <= 1'b0;
          pend_a[p] <= '0;
          last_acc[p] <= 1'b0;
        end else begin
          st[p] <= next_st;
          beat[p] <= next_beat;
          base[p] <= next_base;
          pend_v[p] <= next_pend_v;
          pend_a[p] <= next_pend_a;
          last_acc[p] <= next_last;
        end
      end
    end
  endgenerate

  // ======================================================
  // write data capture, one beat per core edge
  logic [`SR_DATA_W-1:0] d_q;   // beat data held one cycle
  logic [`SR_LANES-1:0] bw_q;   // its lane strobes
  wbeat_t push_beat;            // beat entering the fifo
  wbeat_t head;                 // beat leaving the fifo
  logic push_ok, head_v, drain;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      d_q <= `SR_DATA_RST;
      bw_q <= `SR_MASK_RST;
    end else begin
      d_q <= WR_DATA_IN;
      bw_q <= LANE_WRITE_EN_N_IN; // per-beat value [R03]
    end
  end

  always_comb begin
    push_beat.addr = burst_addr[1];
    // strobes reach the array only while bursting [R02]
    push_beat.lane_write_en_n = cons[1] ? bw_q : `SR_MASK_RST;
    push_beat.data = d_q;
    drain = head_v && !DRAIN_HOLD_IN;
  end

  // stalls on the drain side back up to the request gate
  beat_fifo #(
    .W($bits(wbeat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .in_valid_in(cons[1]),
    .in_ready_out(push_ok),
    .in_data_in(push_beat),
    .out_valid_out(head_v),
    .out_ready_in(!DRAIN_HOLD_IN),
    .out_data_out(head),
    .level_out(fifo_level)
  );

  // ======================================================
  // storage array, lane-masked writes
  logic [`SR_DATA_W-1:0] mem [2**MW];

  generate
    for (p = 0; p < `SR_LANES; p++) begin : g_lane
      always_ff @(posedge CORE_CLK_IN) begin
        // disabled lane leaves old bits alone [R13]
        if (drain && !head.lane_write_en_n[p]) begin
          mem[head.addr][p*`SR_LANE_W +: `SR_LANE_W] <=
            head.data[p*`SR_LANE_W +: `SR_LANE_W]; // [R01]
        end
      end
    end
  endgenerate

  // ======================================================
  // read output pipe, two stages to hit t+2
  logic [`SR_DATA_W-1:0] q_pipe, next_q_pipe, next_rd;
  logic q_pipe_v, next_q_pipe_v, next_oe;

  always_comb begin
    next_q_pipe = cons[0] ? mem[burst_addr[0]] : q_pipe;
    next_q_pipe_v = cons[0];
    next_rd = q_pipe;
    next_oe = q_pipe_v; // idle cycles leave the port undriven [R10]
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      q_pipe <= `SR_DATA_RST;
      q_pipe_v <= 1'b0;
      RD_DATA_OUT <= `SR_DATA_RST;
      RD_OE_OUT <= 1'b0;
    end else begin
      q_pipe <= next_q_pipe;
      q_pipe_v <= next_q_pipe_v;
      RD_DATA_OUT <= next_rd;
      RD_OE_OUT <= next_oe; // [R12]
    end
  end

  // ======================================================
  // checks
  a_read_prio: assert property (@(posedge CORE_CLK_IN) // [R07]
    disable iff (!RESET_N_IN)
    (k_rise && !RD_REQ_N_IN && !WR_REQ_N_IN && st[1] == ST_IDLE)
    |=> st[1] == ST_IDLE)
    else $error("write started beside a read");

  a_four_beats: assert property (@(posedge CORE_CLK_IN) // [R05]
    disable iff (!RESET_N_IN)
    (st[0] == ST_LEAD && k_rise) |=> cons[0] [*4])
    else $error("read burst not four beats");

  a_state_on_k: assert property (@(posedge CORE_CLK_IN) // [R08]
    disable iff (!RESET_N_IN)
    (st[1] != $past(st[1])) |-> $past(k_rise))
    else $error("state moved off a true edge");

  a_addr_step: assert property (@(posedge CORE_CLK_IN) // [R04]
    disable iff (!RESET_N_IN)
    (cons[1] && beat[1] != 2'h3)
    |=> burst_addr[1] == $past(burst_addr[1]) + 1'b1)
    else $error("burst address out of order");

  a_rd_latency: assert property (@(posedge CORE_CLK_IN) // [R10]
    disable iff (!RESET_N_IN)
    acc[0] |-> ##5 RD_OE_OUT [*4])
    else $error("read beats late or short");

  a_wr_latency: assert property (@(posedge CORE_CLK_IN) // [R09]
    disable iff (!RESET_N_IN)
    acc[1] |-> ##3 (cons[1] && push_ok) [*4])
    else $error("write beats not taken on time");

  a_no_repeat: assert property (@(posedge CORE_CLK_IN) // [R11]
    disable iff (!RESET_N_IN)
    acc[0] |-> ##2 !acc[0])
    else $error("repeated read request taken");

  a_quiet_idle: assert property (@(posedge CORE_CLK_IN) // [R12]
    disable iff (!RESET_N_IN)
    RD_OE_OUT |-> $past(cons[0], 2))
    else $error("read port driven without burst");

  // nothing may enter the fifo while no write burst runs
  a_mask_gate: assert property (@(posedge CORE_CLK_IN) // [R02]
    disable iff (!RESET_N_IN)
    !cons[1] |=> fifo_level <= $past(fifo_level))
    else $error("beat entered outside a burst");

  c_rd_burst: cover property (@(posedge CORE_CLK_IN)
    disable iff (!RESET_N_IN) acc[0] ##5 RD_OE_OUT [*4]);
  c_wr_burst: cover property (@(posedge CORE_CLK_IN)
    disable iff (!RESET_N_IN) acc[1] ##3 cons[1] [*4]);
  c_overlap: cover property (@(posedge CORE_CLK_IN)
    disable iff (!RESET_N_IN) cons[0] && cons[1]);
  c_chained: cover property (@(posedge CORE_CLK_IN)
    disable iff (!RESET_N_IN) pend_v[1] && st[1] == ST_BEAT);
endmodule : burst_sram_bus

// ==== sim/mem_ctrl_model.sv ====
`timescale 1ns/1ps
// ======================================================
// far-side controller: requests and write beats
module mem_ctrl_model (
  input wire logic clk_in,         // core clock
  input wire logic k_phase_in,     // high: next edge is true
  output logic rd_req_n_out,       // read request, low
  output logic wr_req_n_out,       // write request, low
  output logic [7:0] addr_out,     // burst base
  output logic [17:0] wr_data_out, // write beat
  output logic [1:0] lane_out      // lane strobes, low
);
  logic busy = 1'b0;               // beats on the lines
  logic [17:0] beat_d = 18'h00000; // current beat data
  logic [1:0] beat_m = 2'h3;       // current beat lanes
  logic [17:0] idle_d = 18'h2AAAA; // idle pattern
  initial begin
    rd_req_n_out = 1'b1;
    wr_req_n_out = 1'b1;
    addr_out = 8'h00;
  end
  // idle lines flip every cycle, so stale data never looks valid
  always @(negedge clk_in) idle_d <= ~idle_d;
  assign wr_data_out = busy ? beat_d : idle_d;
  // stray strobes outside bursts, one lane low each cycle
  assign lane_out = busy ? beat_m : idle_d[1:0];
  // ======================================================
  // wait for the fall before an edge of the wanted phase
  task automatic to_edge(input logic ph);
    @(negedge clk_in);
    while (k_phase_in !== ph) @(negedge clk_in);
  endtask : to_edge
  // request held over reps edges of that phase, then released
  task automatic req(input logic rd, input logic wr,
                     input logic [7:0] a, input int reps,
                     input logic ph);
    to_edge(ph);
    rd_req_n_out = ~rd;
    wr_req_n_out = ~wr;
    addr_out = a;
    repeat (2 * reps - 1) @(negedge clk_in);
    rd_req_n_out = 1'b1;
    wr_req_n_out = 1'b1;
    addr_out = ~a;
  endtask : req
  // four beats on the cycles after the request, lanes per beat
  task automatic beats(input logic [71:0] d, input logic [7:0] m);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_in);
      busy = 1'b1;
      beat_d = d[18*k +: 18];
      beat_m = m[2*k +: 2];
    end
    @(negedge clk_in);
    busy = 1'b0;
  endtask : beats
  // eight beats without a gap, for two chained bursts
  task automatic chain(input logic [143:0] d, input logic [15:0] m);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_in);
      busy = 1'b1;
      beat_d = d[18*k +: 18];
      beat_m = m[2*k +: 2];
    end
    @(negedge clk_in);
    busy = 1'b0;
  endtask : chain
endmodule : mem_ctrl_model

// ==== sim/burst_sram_bus_tb.sv ====
`timescale 1ns/1ps
// ======================================================
// bench for the burst bus-cycle block
module burst_sram_bus_tb;
  logic clk = 1'b0;   // core clock
  logic rst_n = 1'b0; // reset, low
  logic hold = 1'b0;  // stall fifo drain
  logic rd_n, wr_n, kph, wrdy, oe;
  logic [7:0] addr;
  logic [17:0] wd, rd;
  logic [1:0] ln;
  logic [17:0] ref_m [1024]; // expected array
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  burst_sram_bus #(.ADDR_W(8), .FIFO_DEPTH(16)) burst_sram_bus_inst (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .RD_REQ_N_IN(rd_n),
    .WR_REQ_N_IN(wr_n), .ADDR_IN(addr), .WR_DATA_IN(wd),
    .LANE_WRITE_EN_N_IN(ln), .DRAIN_HOLD_IN(hold),
    .K_PHASE_OUT(kph), .WR_READY_OUT(wrdy), .RD_DATA_OUT(rd),
    .RD_OE_OUT(oe));
  mem_ctrl_model ctrl_inst (
    .clk_in(clk), .k_phase_in(kph), .rd_req_n_out(rd_n),
    .wr_req_n_out(wr_n), .addr_out(addr), .wr_data_out(wd),
    .lane_out(ln));
  // ======================================================
  // helpers
  task automatic chk(input string nm, input logic [17:0] e,
                     input logic [17:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // expected array follows one write burst, lane by lane
  task automatic note(input logic [7:0] a, input logic [71:0] d,
                      input logic [7:0] m);
    for (int j = 0; j < 8; j++)
      if (!m[j]) ref_m[{a, j[2:1]}][9*(j%2) +: 9] = d[9*j +: 9];
  endtask : note
  // write burst; expected array follows only if it is accepted
  task automatic put(input logic [7:0] a, input logic [71:0] d,
                     input logic [7:0] m, input logic ok);
    ctrl_inst.req(1'b0, 1'b1, a, 1, 1'b1);
    ctrl_inst.beats(d, m);
    if (ok) note(a, d, m);
  endtask : put
  // beats seen four cycles after the taken edge, then quiet
  task automatic look(input logic [7:0] a, input int w);
    repeat (w) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      chk("read enable", 18'h00001, {17'h0, oe});
      chk("read beat", ref_m[{a, k[1:0]}], rd);
    end
    @(negedge clk);
    chk("read end", 18'h00000, {17'h0, oe});
  endtask : look
  task automatic get(input logic [7:0] a);
    ctrl_inst.req(1'b1, 1'b0, a, 1, 1'b1);
    look(a, 3);
  endtask : get
  // ======================================================
  // scenarios
  task automatic t_idle();
    logic p;
    chk("reset enable", 18'h00000, {17'h0, oe});
    chk("reset ready", 18'h00001, {17'h0, wrdy});
    rst_n = 1'b1;
    p = kph;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      chk("phase", {17'h0, ~p}, {17'h0, kph});
      p = kph;
    end
    ctrl_inst.req(1'b1, 1'b0, 8'h10, 1, 1'b0);
    repeat (8) begin
      @(negedge clk);
      chk("odd edge read", 18'h00000, {17'h0, oe});
    end
  endtask : t_idle
  // full write, then one lane pattern per beat over it
  task automatic t_lanes();
    put(8'h10, 72'hA5A5_5A5A_C3C3_3C3C_1, 8'h00, 1'b1);
    put(8'h10, 72'h0, 8'hE4, 1'b1);
    repeat (8) @(negedge clk);
    get(8'h10);
  endtask : t_lanes
  // read and write on one edge: only the read runs
  task automatic t_tie();
    put(8'h30, 72'h1234_5678_9ABC_DEF0_7, 8'h00, 1'b1);
    repeat (8) @(negedge clk);
    ctrl_inst.req(1'b1, 1'b1, 8'h30, 1, 1'b1);
    fork
      ctrl_inst.beats(72'h0, 8'h00);
      look(8'h30, 3);
    join
    repeat (8) @(negedge clk);
    get(8'h30);
  endtask : t_tie
  // read starts while a write burst is running
  task automatic t_both();
    fork
      put(8'h40, {4{18'h2D2D2}}, 8'h00, 1'b1);
      begin
        // one true edge after the write, whatever the phase
        repeat (2) @(negedge clk);
        get(8'h30);
      end
    join
    repeat (8) @(negedge clk);
    get(8'h40);
  endtask : t_both
  // write on the next allowed true edge chains on without a gap
  task automatic t_chain();
    logic [71:0] b0, b1;
    b0 = {18'h04444, 18'h03333, 18'h02222, 18'h01111};
    b1 = {18'h08888, 18'h07777, 18'h06666, 18'h05555};
    ctrl_inst.req(1'b0, 1'b1, 8'h60, 1, 1'b1);
    fork
      ctrl_inst.chain({b1, b0}, 16'h0000);
      begin
        @(negedge clk);
        ctrl_inst.req(1'b0, 1'b1, 8'h61, 1, 1'b1);
      end
    join
    note(8'h60, b0, 8'h00);
    note(8'h61, b1, 8'h00);
    repeat (8) @(negedge clk);
    get(8'h60);
    get(8'h61);
  endtask : t_chain
  // read held over two true edges: second one ignored
  task automatic t_rep();
    ctrl_inst.req(1'b1, 1'b0, 8'h30, 2, 1'b1);
    look(8'h30, 1);
  endtask : t_rep
  // fill the stalled fifo until writes are refused
  task automatic t_fill();
    put(8'h53, {4{18'h0F0F0}}, 8'h00, 1'b1);
    repeat (8) @(negedge clk);
    hold = 1'b1;
    put(8'h50, {4{18'h11111}}, 8'h00, 1'b1);
    put(8'h51, {4{18'h22222}}, 8'h00, 1'b1);
    chk("ready two bursts", 18'h00001, {17'h0, wrdy});
    put(8'h52, {4{18'h33333}}, 8'h00, 1'b1);
    @(negedge clk);
    chk("ready three bursts", 18'h00000, {17'h0, wrdy});
    put(8'h53, 72'h0, 8'h00, 1'b0);
    hold = 1'b0;
    repeat (30) @(negedge clk);
    get(8'h50);
    get(8'h52);
    get(8'h53);
  endtask : t_fill
  // ======================================================
  // verdict and hang guard
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // whole run is a few hundred cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    t_idle();
    t_lanes();
    t_tie();
    t_both();
    t_chain();
    t_rep();
    t_fill();
    summarize();
  end
endmodule : burst_sram_bus_tb
